// ==== dv/isp_cpu_model.sv ====
// Purpose: CPU core and request sources facing the block
// Assumes: Calls start just after a rising edge
// Notes:   Keeps its own stack of pushed cc images
`timescale 1ns/100ps
module isp_cpu_model #(
    parameter int NUM_VEC = 14
) (
    input  logic                       hclk,
    input  logic [7:0]                 cc_out,
    output isp_pkg::isp_cpu_event_type cpu_event,
    output logic [NUM_VEC-1:0]         irq_pending
);
    logic [7:0] stack [$];
    initial begin
        cpu_event   = '0;
        irq_pending = '0;
    end
    task automatic enter(input logic trap, input logic [3:0] vec);
        cpu_event.int_enter  <= !trap;
        cpu_event.trap_enter <= trap;
        cpu_event.int_vector <= vec;
        @(posedge hclk);
        // Image that this entry replaces, incl. an op of the last edge
        stack.push_back(cc_out);
        cpu_event.int_enter  <= 1'b0;
        cpu_event.trap_enter <= 1'b0;
    endtask : enter
    task automatic op(input isp_pkg::isp_op_type o);
        cpu_event.op <= o;
        @(posedge hclk);
        cpu_event.op <= isp_pkg::ISP_OP_NONE;
    endtask : op
    task automatic ret();
        cpu_event.pop_valid     <= 1'b1;
        cpu_event.pop_is_return <= 1'b1;
        cpu_event.pop_data      <= stack.pop_back();
        @(posedge hclk);
        cpu_event.pop_valid     <= 1'b0;
        // Stale data must not look like a valid image
        cpu_event.pop_data      <= ~cpu_event.pop_data;
    endtask : ret
endmodule : isp_cpu_model

// ==== dv/isp_priority_ctrl_properties.sv ====
// Purpose: Port-level checks of the software-priority block
// Assumes: One clock domain, async active-low reset
// Notes:   Bound from the testbench top file
`timescale 1ns/100ps
module isp_priority_ctrl_properties #(
    parameter int NUM_VEC = 14
) (
    input logic                       hclk,
    input logic                       hresetn,
    input logic                       hsel,
    input logic [1:0]                 htrans,
    input logic                       hready,
    input logic                       hreadyout,
    input isp_pkg::isp_cpu_event_type cpu_event,
    input logic [NUM_VEC-1:0]         irq_pending,
    input isp_pkg::isp_irq_type       irq,
    input logic [7:0]                 cc_out
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [1:0] lvl;
    logic       calm;
    assign lvl  = {cc_out[5], cc_out[3]};
    // Ops lose to pop, entry and trap in the same cycle
    assign calm = !cpu_event.int_enter && !cpu_event.trap_enter
                  && !cpu_event.pop_valid;
    a_trap_top: assert property (
        cpu_event.trap_enter |=> lvl == 2'b11) else $error("trap level");
    a_disable_lvl: assert property (
        calm && cpu_event.op == isp_pkg::ISP_OP_DISABLE |=> lvl == 2'b11)
        else $error("disable level");
    a_enable_lvl: assert property (
        calm && cpu_event.op == isp_pkg::ISP_OP_ENABLE |=> lvl == 2'b10)
        else $error("enable level");
    a_wait_lvl: assert property (
        calm && cpu_event.op == isp_pkg::ISP_OP_WAIT |=> lvl == 2'b10)
        else $error("wait level");
    a_halt_lvl: assert property (
        calm && cpu_event.op == isp_pkg::ISP_OP_HALT |=> lvl == 2'b10)
        else $error("halt level");
    a_pop_restore: assert property (
        cpu_event.pop_valid && !cpu_event.int_enter
        && !cpu_event.trap_enter |=> lvl == {$past(cpu_event.pop_data[5]),
        $past(cpu_event.pop_data[3])}) else $error("pop level");
    a_top_ones: assert property (
        cc_out[7:6] == 2'b11) else $error("cc top bits");
    a_req_masked: assert property (
        irq.req |-> $past(lvl) != 2'b11) else $error("req at level 3");
    a_req_pending: assert property (
        irq.req |-> |($past(irq_pending) & (NUM_VEC'(1) << irq.vector)))
        else $error("req without pending");
    a_one_wait: assert property (
        hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
        else $error("bus wait state");
    c_trap: cover property (cpu_event.trap_enter);
    c_req: cover property (irq.req);
    c_ret: cover property (cpu_event.pop_valid && cpu_event.pop_is_return);
endmodule : isp_priority_ctrl_properties

// ==== dv/test_interrupt_software_priority.sv ====
// Purpose: Self-checking bench of the software-priority block
// Assumes: Bus answers with one wait state per transfer
// Notes:   Levels compared as {high,low} priority bits
`timescale 1ns/100ps
`include "isp_defines.svh"
module test_interrupt_software_priority;
    logic                       hclk;
    logic                       hresetn;
    logic                       hsel;
    logic [31:0]                haddr;
    logic [1:0]                 htrans;
    logic                       hwrite;
    logic [31:0]                hwdata;
    logic [31:0]                hrdata;
    logic                       hreadyout;
    logic                       hresp;
    isp_pkg::isp_cpu_event_type cpu_event;
    logic [13:0]                irq_pending;
    isp_pkg::isp_irq_type       irq;
    logic [7:0]                 cc_out;
    logic [31:0]                rd;
    int                         fails;
    int                         checks_done;

    isp_priority_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .cpu_event(cpu_event),
        .irq_pending(irq_pending), .irq(irq), .cc_out(cc_out));
    isp_cpu_model u_cpu (.hclk(hclk), .cc_out(cc_out),
        .cpu_event(cpu_event), .irq_pending(irq_pending));

    initial hclk = 1'b0;
    always #2 hclk = ~hclk;

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        haddr  <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", 32'h0000_0000, 32'(hresp));
    endtask : bus
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk("hrdata", e, rd);
    endtask : rchk
    task automatic lvl(input logic [1:0] e);
        repeat (2) @(posedge hclk);
        chk("level", 32'(e), 32'({cc_out[5], cc_out[3]}));
    endtask : lvl
    task automatic irqchk(input logic r, input logic [3:0] v);
        repeat (2) @(posedge hclk);
        chk("irq req", 32'(r), 32'(irq.req));
        if (r) chk("irq vector", 32'(v), 32'(irq.vector));
    endtask : irqchk
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done

    task automatic t_reset;
        chk("cc_out", 32'h0000_00EA, 32'(cc_out));
        rchk(`ISP_OFF_CC, 32'h0000_00EA);
        for (int i = 1; i < 5; i++) rchk(8'(4 * i), 32'h0000_00FF);
    endtask : t_reset
    task automatic t_filter;
        bus(1'b1, `ISP_OFF_VP0, 32'h0000_00CF);
        bus(1'b1, `ISP_OFF_VP0, 32'h0000_0064);
        rchk(`ISP_OFF_VP0, 32'h0000_0044);
        bus(1'b1, `ISP_OFF_VP3, 32'h0000_0000);
        rchk(`ISP_OFF_VP3, 32'h0000_00F0);
        rchk(8'h40, 32'h0000_0000);
    endtask : t_filter
    task automatic t_ops;
        isp_pkg::isp_op_type o [4];
        logic [1:0]          e [4];
        o = '{isp_pkg::ISP_OP_ENABLE, isp_pkg::ISP_OP_DISABLE,
              isp_pkg::ISP_OP_HALT, isp_pkg::ISP_OP_WAIT};
        e = '{2'b10, 2'b11, 2'b10, 2'b10};
        foreach (o[i]) begin
            u_cpu.op(o[i]);
            lvl(e[i]);
        end
        bus(1'b1, `ISP_OFF_CC, 32'h0000_0008);
        rchk(`ISP_OFF_CC, 32'h0000_00C8);
        lvl(2'b01);
    endtask : t_ops
    task automatic t_entry;
        bus(1'b1, `ISP_OFF_VP1, 32'h0000_00F3);
        bus(1'b1, `ISP_OFF_VP3, 32'h0000_000C);
        rchk(`ISP_OFF_VP3, 32'h0000_00FC);
        rchk(`ISP_OFF_VP1, 32'h0000_00F3);
        u_cpu.enter(1'b0, 4'd5);
        lvl(2'b00);
        u_cpu.enter(1'b0, 4'd13);
        lvl(2'b11);
        u_cpu.ret();
        lvl(2'b00);
        u_cpu.ret();
        u_cpu.op(isp_pkg::ISP_OP_ENABLE);
        u_cpu.enter(1'b0, 4'd14);
        lvl(2'b10);
        u_cpu.ret();
        u_cpu.op(isp_pkg::ISP_OP_DISABLE);
        u_cpu.enter(1'b1, 4'd0);
        lvl(2'b11);
        u_cpu.ret();
        u_cpu.op(isp_pkg::ISP_OP_ENABLE);
        u_cpu.enter(1'b1, 4'd0);
        lvl(2'b11);
        u_cpu.ret();
    endtask : t_entry
    task automatic t_arb;
        bus(1'b1, `ISP_OFF_VP0, 32'h0000_0000);
        u_cpu.op(isp_pkg::ISP_OP_ENABLE);
        u_cpu.irq_pending <= 14'h0006;
        irqchk(1'b1, 4'd1);
        u_cpu.enter(1'b0, 4'd1);
        irqchk(1'b0, 4'd0);
        rchk(`ISP_OFF_STATUS, 32'h0000_0011);
        bus(1'b1, `ISP_OFF_VP0, 32'h0000_000C);
        irqchk(1'b1, 4'd1);
        bus(1'b1, `ISP_OFF_VP0, 32'h0000_0004);
        irqchk(1'b0, 4'd0);
        u_cpu.ret();
        irqchk(1'b1, 4'd1);
        u_cpu.op(isp_pkg::ISP_OP_DISABLE);
        irqchk(1'b0, 4'd0);
        u_cpu.irq_pending <= 14'h0000;
    endtask : t_arb

    initial begin
        fails       = 0;
        checks_done = 0;
        hresetn     = 1'b0;
        hsel        = 1'b1;
        haddr       = '0;
        htrans      = 2'b00;
        hwrite      = 1'b0;
        hwdata      = '0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset;
        t_filter;
        t_ops;
        t_entry;
        t_arb;
        test_done;
    end
    // Whole run needs about 120 cycles
    initial begin
        repeat (4000) @(posedge hclk);
        fails++;
        test_done;
    end
endmodule : test_interrupt_software_priority

bind isp_priority_ctrl isp_priority_ctrl_properties #(.NUM_VEC(NUM_VEC))
    u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .htrans(htrans), .hready(hready), .hreadyout(hreadyout),
        .cpu_event(cpu_event), .irq_pending(irq_pending), .irq(irq),
        .cc_out(cc_out));

// ==== pkg/isp_defines.svh ====
// Purpose: Offsets, field positions, reset values and level codes
// Assumes: 32-bit AHB-Lite register bus, one register per word
// Notes:   Definitions only
`ifndef ISP_DEFINES_SVH
`define ISP_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ISP_OFF_CC        8'h00
`define ISP_OFF_VP0       8'h04
`define ISP_OFF_VP1       8'h08
`define ISP_OFF_VP2       8'h0C
`define ISP_OFF_VP3       8'h10
`define ISP_OFF_STATUS    8'h14

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define ISP_CC_PRIO_HI    5
`define ISP_CC_PRIO_LO    3
`define ISP_CC_RESET      8'hEA
`define ISP_CC_ONES_MASK  8'hC0
`define ISP_VP_RESET      8'hFF
`define ISP_VP3_RO_MASK   8'hF0
`define ISP_NUM_VEC       14
`define ISP_NUM_VP        4

// ----------------------------------------------------------------
// Priority level codes {high,low}
// ----------------------------------------------------------------
`define ISP_LVL0          2'b10
`define ISP_LVL1          2'b01
`define ISP_LVL2          2'b00
`define ISP_LVL3          2'b11

`endif

// ==== pkg/isp_pkg.sv ====
// Purpose: Types shared by the software-priority block
// Assumes: Constants live in isp_defines.svh
// Notes:   Types only
package isp_pkg;

    // ------------------------------------------------------------
    // CPU side
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ISP_OP_NONE,
        ISP_OP_ENABLE,
        ISP_OP_DISABLE,
        ISP_OP_HALT,
        ISP_OP_WAIT
    } isp_op_type;

    typedef struct packed {
        logic       int_enter;
        logic [3:0] int_vector;
        logic       trap_enter;
        isp_op_type op;
        logic       pop_valid;
        logic       pop_is_return;
        logic [7:0] pop_data;
    } isp_cpu_event_type;

    typedef struct packed {
        logic       req;
        logic [3:0] vector;
    } isp_irq_type;

    // ------------------------------------------------------------
    // Bus slave and block state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ISP_BUS_IDLE,
        ISP_BUS_WAIT,
        ISP_BUS_DONE
    } isp_bus_state_type;

    typedef struct packed {
        logic [7:0]        cc;
        isp_bus_state_type bus;
        logic [7:0]        addr;
        logic              write;
        logic [31:0]       hrdata;
        logic [3:0]        active_vec;
        logic              active_valid;
        logic              irq_req;
        logic [3:0]        irq_vec;
    } isp_state_type;

endpackage : isp_pkg

// ==== verilog/isp_priority_ctrl.sv ====
// Purpose: Current software priority, entry loading and arbitration
// Assumes: CPU signals are synchronous to hclk; one wait per access
// Notes:   The CPU pushes cc_out itself before using an entry pulse
`timescale 1ns/100ps
`include "isp_defines.svh"

// Functional notes
// - Current priority is CC bit 5 (high) and bit 3 (low).
// - Codes: level0=10, level1=01, level2=00, level3=11; 3 disables.
// - Interrupt entry loads the vector's stored field into CC.
// - Enable, disable, halt, wait, return and pop also change it.
// - Trap and reset still act while running at level 3.
// - Four byte registers hold fields of vectors 0 to 13.
// - Field 0 is the topmost vector, downward to field 13.
// - Stored fields use the same level codes as CC.
// - Writing level 0 to a field keeps its old value.
// - Trap or reset entry sets both priority bits.
// - Raising a running, pending vector's field re-enters it.
// - Otherwise new field takes effect at that vector's next request.
// - CC resets to 111x1010, priority level 3.
// - Vector registers reset to FFh; last one's top nibble reads ones.
// - Halt forces priority code 10 so a pending request wakes.
// - CC pushed before entry; popping restores the prior priority.
module isp_priority_ctrl #(
    parameter int NUM_VEC = `ISP_NUM_VEC
) (
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    // AHB-Lite slave
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic      [31:0]               hrdata,
    output logic                           hreadyout,
    output logic                           hresp,
    // CPU core and request sources
    input  wire isp_pkg::isp_cpu_event_type cpu_event,
    input  wire logic [NUM_VEC-1:0]        irq_pending,
    output isp_pkg::isp_irq_type           irq,
    output logic      [7:0]                cc_out
);

    isp_pkg::isp_state_type state;
    isp_pkg::isp_state_type next_state;

    logic [31:0] fields_flat;
    logic [7:0]  bank_rd_data;
    logic        bank_wr_en;
    logic [1:0]  bank_wr_idx;
    logic [1:0]  bank_rd_idx;
    logic        addr_phase;
    logic        found;
    logic [3:0]  found_vec;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Level codes are not monotonic, so every compare goes by rank
    function automatic logic [1:0] rank(input logic [1:0] code);
        logic [1:0] r;
        unique case (code)
            `ISP_LVL0: r = 2'd0;
            `ISP_LVL1: r = 2'd1;
            `ISP_LVL2: r = 2'd2;
            `ISP_LVL3: r = 2'd3;
        endcase
        return r;
    endfunction : rank

    function automatic logic [1:0] cc_prio(input logic [7:0] cc);
        return {cc[`ISP_CC_PRIO_HI], cc[`ISP_CC_PRIO_LO]};
    endfunction : cc_prio

    function automatic logic [7:0] set_prio(input logic [7:0] cc,
                                            input logic [1:0] code);
        logic [7:0] res;
        res = cc;
        res[`ISP_CC_PRIO_HI] = code[1];
        res[`ISP_CC_PRIO_LO] = code[0];
        return res | `ISP_CC_ONES_MASK;
    endfunction : set_prio

    function automatic logic [1:0] vec_field(input logic [31:0] f,
                                             input logic [3:0]  vec);
        return f[vec*2 +: 2];
    endfunction : vec_field

    function automatic logic is_vp(input logic [7:0] a);
        return a == `ISP_OFF_VP0 || a == `ISP_OFF_VP1 ||
               a == `ISP_OFF_VP2 || a == `ISP_OFF_VP3;
    endfunction : is_vp

    function automatic logic [1:0] vp_index(input logic [7:0] a);
        logic [7:0] d;
        d = a - `ISP_OFF_VP0;
        return d[3:2];
    endfunction : vp_index

    // ------------------------------------------------------------
    // Vector priority registers
    // ------------------------------------------------------------
    isp_vector_bank #(
        .NUM_REG (`ISP_NUM_VP)
    ) u_bank (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr_en   (bank_wr_en),
        .wr_idx  (bank_wr_idx),
        .wr_data (hwdata[7:0]),
        .rd_idx  (bank_rd_idx),
        .rd_data (bank_rd_data),
        .fields  (fields_flat)
    );

    // ------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------
    // Lowest vector number wins among those above the current level.
    // A raised field of a running vector that is still pending beats
    // the level loaded at its entry, so it re-enters; a lowered or
    // equal one does not, and the running level stays as loaded.
    always_comb begin
        found     = 1'b0;
        found_vec = 4'h0;
        for (int v = NUM_VEC - 1; v >= 0; v--) begin
            if (irq_pending[v] &&
                rank(vec_field(fields_flat, 4'(v))) >
                rank(cc_prio(state.cc))) begin
                found     = 1'b1;
                found_vec = 4'(v);
            end
        end
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign addr_phase  = hsel && htrans[1] && hready;
    assign bank_wr_en  = state.bus == isp_pkg::ISP_BUS_WAIT &&
                         state.write && is_vp(state.addr);
    assign bank_wr_idx = vp_index(state.addr);
    // Read index taken in the address phase, so the bank's registered
    // data already stands in the wait cycle
    assign bank_rd_idx = vp_index(haddr[7:0]);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;

        // Arbiter result, registered for the CPU
        next_state.irq_req = found;
        next_state.irq_vec = found_vec;

        // Bus slave: one wait cycle, read data from a register
        unique case (state.bus)
            isp_pkg::ISP_BUS_IDLE,
            isp_pkg::ISP_BUS_DONE: begin
                if (addr_phase) begin
                    next_state.bus   = isp_pkg::ISP_BUS_WAIT;
                    next_state.addr  = haddr[7:0];
                    next_state.write = hwrite;
                end else begin
                    next_state.bus = isp_pkg::ISP_BUS_IDLE;
                end
            end
            isp_pkg::ISP_BUS_WAIT: begin
                next_state.bus    = isp_pkg::ISP_BUS_DONE;
                next_state.hrdata = 32'h0000_0000;
                if (state.write) begin
                    if (state.addr == `ISP_OFF_CC) begin
                        next_state.cc = hwdata[7:0] | `ISP_CC_ONES_MASK;
                    end
                end else if (state.addr == `ISP_OFF_CC) begin
                    next_state.hrdata = {24'h00_0000, state.cc};
                end else if (is_vp(state.addr)) begin
                    next_state.hrdata = {24'h00_0000, bank_rd_data};
                end else if (state.addr == `ISP_OFF_STATUS) begin
                    next_state.hrdata = {22'h00_0000,
                                         state.irq_req,
                                         state.irq_vec,
                                         state.active_valid,
                                         state.active_vec};
                end
            end
        endcase

        // CPU events; later ones take precedence in one cycle
        unique case (cpu_event.op)
            isp_pkg::ISP_OP_ENABLE: begin
                next_state.cc = set_prio(state.cc, `ISP_LVL0);
            end
            isp_pkg::ISP_OP_DISABLE: begin
                next_state.cc = set_prio(state.cc, `ISP_LVL3);
            end
            isp_pkg::ISP_OP_HALT,
            isp_pkg::ISP_OP_WAIT: begin
                next_state.cc = set_prio(state.cc, `ISP_LVL0);
            end
            isp_pkg::ISP_OP_NONE: begin
            end
            default: begin
            end
        endcase

        if (cpu_event.pop_valid) begin
            next_state.cc = cpu_event.pop_data | `ISP_CC_ONES_MASK;
            if (cpu_event.pop_is_return) begin
                next_state.active_valid = 1'b0;
            end
        end

        if (cpu_event.int_enter &&
            cpu_event.int_vector < 4'(NUM_VEC)) begin
            next_state.cc = set_prio(state.cc,
                                     vec_field(fields_flat,
                                               cpu_event.int_vector));
            next_state.active_vec   = cpu_event.int_vector;
            next_state.active_valid = 1'b1;
        end

        // Trap bypasses the per-vector scheme entirely
        if (cpu_event.trap_enter) begin
            next_state.cc = set_prio(state.cc, `ISP_LVL3);
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state.cc           <= `ISP_CC_RESET;
            state.bus          <= isp_pkg::ISP_BUS_IDLE;
            state.addr         <= 8'h00;
            state.write        <= 1'b0;
            state.hrdata       <= 32'h0000_0000;
            state.active_vec   <= 4'h0;
            state.active_valid <= 1'b0;
            state.irq_req      <= 1'b0;
            state.irq_vec      <= 4'h0;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hrdata     = state.hrdata;
    assign hreadyout  = state.bus != isp_pkg::ISP_BUS_WAIT;
    assign hresp      = 1'b0;
    assign irq.req    = state.irq_req;
    assign irq.vector = state.irq_vec;
    assign cc_out     = state.cc;

endmodule : isp_priority_ctrl

// ==== verilog/isp_vector_bank.sv ====
// Purpose: Four per-vector priority registers with write filter
// Assumes: One write port, one registered read port
// Notes:   All fields also come out flat for the arbiter
`timescale 1ns/100ps
`include "isp_defines.svh"

module isp_vector_bank #(
    parameter int NUM_REG = `ISP_NUM_VP
) (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire logic                   wr_en,
    input  wire logic [1:0]             wr_idx,
    input  wire logic [7:0]             wr_data,
    input  wire logic [1:0]             rd_idx,
    output logic      [7:0]             rd_data,
    output logic      [NUM_REG*8-1:0]   fields
);

    logic [NUM_REG*8-1:0] regs;
    logic [NUM_REG*8-1:0] next_regs;
    logic [7:0]           next_rd_data;

    // ------------------------------------------------------------
    // Write filter
    // ------------------------------------------------------------
    function automatic logic [7:0] merge(input logic [7:0] old_val,
                                         input logic [7:0] new_val,
                                         input logic       last);
        logic [7:0] res;
        res = old_val;
        for (int f = 0; f < 4; f++) begin
            if (new_val[2*f +: 2] != `ISP_LVL0) begin
                res[2*f +: 2] = new_val[2*f +: 2];
            end
        end
        if (last) begin
            res = res | `ISP_VP3_RO_MASK;
        end
        return res;
    endfunction : merge

    always_comb begin
        next_regs = regs;
        if (wr_en) begin
            next_regs[wr_idx*8 +: 8] = merge(regs[wr_idx*8 +: 8], wr_data,
                                             wr_idx == 2'(NUM_REG - 1));
        end
        next_rd_data = regs[rd_idx*8 +: 8];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            regs    <= {NUM_REG{`ISP_VP_RESET}};
            rd_data <= 8'h00;
        end else begin
            regs    <= next_regs;
            rd_data <= next_rd_data;
        end
    end

    assign fields = regs;

endmodule : isp_vector_bank
